// File: pkg/mad_pkg.sv
// shared constants and ball helpers for the multiplexed address link
package mad_pkg;
	// link widths and ball vector layout {cs_n, we_n, ref_n, bank, addr}
	localparam int MAD_ADDR_W = 21;
	localparam int MAD_BANK_W = 4;
	localparam int MAD_BALL_W = 28;
	localparam int MAD_BANKS = 16;

	// command codes as {chip_sel_n, write_en_n, refresh_n}
	localparam logic [2:0] MAD_CMD_NOP = 3'h7;
	localparam logic [2:0] MAD_CMD_MRS = 3'h0;
	localparam logic [2:0] MAD_CMD_WRITE = 3'h1;
	localparam logic [2:0] MAD_CMD_AUTO_REFRESH_CMD = 3'h2;
	localparam logic [2:0] MAD_CMD_READ = 3'h3;

	// mode register select on bank_sel[1:0] during a mode set
	localparam logic [1:0] MAD_MR_SEL_ZERO = 2'h0;
	localparam logic [1:0] MAD_MR_SEL_ONE = 2'h1;
	localparam logic [1:0] MAD_MR_SEL_TWO = 2'h2;

	// mode register fields
	localparam int MAD_MR0_MUX_BIT = 9;
	localparam int MAD_MR1_BL_LSB = 3;
	localparam int MAD_MR1_RTT_LSB = 5;
	localparam int MAD_MR1_MB_BIT = 8;
	localparam logic [1:0] MAD_BL_TWO = 2'h0;
	localparam logic [1:0] MAD_BL_FOUR = 2'h1;
	localparam logic [1:0] MAD_BL_EIGHT = 2'h2;
	localparam logic [1:0] MAD_RTT_OFF = 2'h0;
	localparam logic [20:0] MAD_MR_RESET = 21'h000000;
	localparam logic [20:0] MAD_MR_RSVD_MASK = 21'h1ffc00;

	// first part balls carry their own address bit
	localparam logic [20:0] MAD_AX_MASK = 21'h066739;
	// second part: ball index and the address bit it carries
	localparam int MAD_AY_N = 8;
	localparam int MAD_AY_BALL [0:7] = '{3, 4, 8, 9, 13, 14, 17, 18};
	localparam int MAD_AY_BIT [0:7] = '{1, 2, 6, 7, 11, 12, 16, 15};
	localparam int MAD_AY_BALL_A19 = 10;
	localparam int MAD_AY_BALL_A20 = 5;

	// mirrored partner of each ball about the centre column
	localparam logic [4:0] MAD_MIRROR_PARTNER [0:27] = '{
		5'h1b, 5'h03, 5'h04, 5'h01, 5'h02, 5'h14, 5'h08, 5'h09,
		5'h06, 5'h07, 5'h13, 5'h0d, 5'h0e, 5'h0b, 5'h0c, 5'h12,
		5'h11, 5'h10, 5'h0f, 5'h0a, 5'h05, 5'h16, 5'h15, 5'h18,
		5'h17, 5'h1a, 5'h19, 5'h00};

	// timing
	localparam int MAD_CLK_PERIOD_NS = 8;
	localparam int MAD_MODE_SET_DELAY_NS = 100;
	localparam logic [7:0] MAD_MODE_SET_DELAY_CYC = 8'((MAD_MODE_SET_DELAY_NS
		+ MAD_CLK_PERIOD_NS - 1) / MAD_CLK_PERIOD_NS);
	localparam int MAD_FOUR_ACT_WINDOW_NS = 80;
	localparam logic [7:0] MAD_FOUR_ACT_WINDOW_CYC = 8'((MAD_FOUR_ACT_WINDOW_NS
		+ MAD_CLK_PERIOD_NS - 1) / MAD_CLK_PERIOD_NS);
	localparam logic [1:0] MAD_MULTIBANK_SPACING_CYC = 2'h2;
	localparam logic [4:0] MAD_MAX_REFRESH_BANKS = 5'h04;
	localparam logic [4:0] MAD_MMD_FREE_BANKS = 5'h02;

	// swap balls with their mirror partners when the strap is high
	function automatic logic [27:0] mad_mirror(input logic [27:0] b,
		input logic m);
		logic [27:0] r;
		r = b;
		if (m) begin
			for (int i = 0; i < MAD_BALL_W; i++) begin
				r[i] = b[MAD_MIRROR_PARTNER[i]];
			end
		end
		return r;
	endfunction : mad_mirror
endpackage : mad_pkg

// File: pkg/mad_link_if.sv
// command and address balls between controller and memory
`timescale 1ns/1ns
`default_nettype none

interface mad_link_if;
	logic chip_sel_n;
	logic write_en_n;
	logic refresh_n;
	logic [3:0] bank_sel;
	logic [20:0] addr_ball;

	modport ctrl (
		output chip_sel_n,
		output write_en_n,
		output refresh_n,
		output bank_sel,
		output addr_ball
	);

	modport dram (
		input chip_sel_n,
		input write_en_n,
		input refresh_n,
		input bank_sel,
		input addr_ball
	);
endinterface : mad_link_if

`default_nettype wire

// File: hw/mad_dram_end.sv
// memory end: command capture, address assembly and mode state
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE1 - strap high mirrors balls about column seven
// RULE2 - mode set with zero-register bit nine enters muxing
// RULE3 - controller waits mode-set delay after switching
// RULE4 - controller rewrites zero register keeping bit nine
// RULE5 - muxed mode writes arrive in two parts
// RULE6 - mode sets drive bank bits 2,3 low
// RULE7 - no burst of eight on wide part
// RULE8 - wide part address split across two parts
// RULE9 - narrow part adds bits twenty and nineteen
// RULE10 - latency starts at the second address part
// RULE11 - row cycle starts at command edge
// RULE12 - refresh executes on the following edge
// RULE13 - bank refresh allows next command next clock
// RULE14 - multibank refresh blocks next command two clocks
// RULE15 - multibank refresh obeys window and spacing limits
// RULE16 - address lines select banks only for multibank
// RULE17 - bank lines used only for bank refresh
// RULE18 - termination follows register one after register two
// RULE19 - address bits pick banks, four at most
// RULE20 - capture both parts on consecutive edges
module mad_dram_end #(
	parameter bit IS_X36 = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	mad_link_if.dram link,
	input wire logic ball_mirror_strap,
	output logic exec_valid,
	output logic [2:0] exec_cmd,
	output logic [20:0] exec_addr,
	output logic [3:0] exec_bank,
	output logic [15:0] refresh_mask,
	output logic refresh_err,
	output logic lat_start,
	output logic row_start,
	output logic [3:0] row_bank,
	output logic muxed_mode,
	output logic [1:0] burst_len,
	output logic rtt_on,
	output logic [1:0] rtt_sel
);
	typedef enum logic [1:0] {
		MAD_PH_CMD = 2'b01,
		MAD_PH_SECOND = 2'b10
	} mad_phase_t;

	logic strap_meta_q;
	logic strap_q;
	logic [27:0] pins;
	logic [2:0] cmd;
	logic [3:0] ba;
	logic [20:0] ab;
	logic issue;
	logic multibank;
	logic bank_ref;
	mad_phase_t phase_q;
	mad_phase_t phase_d;
	logic pend_bref_q;
	logic [2:0] held_cmd_q;
	logic [20:0] held_ax_q;
	logic [3:0] held_ba_q;
	logic muxed_q;
	logic mr2_done_q;
	logic [20:0] mr0_q;
	logic [20:0] mr1_q;
	logic [20:0] mr2_q;
	logic [1:0] burst;
	logic go;
	logic [2:0] ecmd;
	logic [20:0] eaddr;
	logic [3:0] eba;
	logic [15:0] mask;
	logic exec_valid_q;
	logic [2:0] exec_cmd_q;
	logic [20:0] exec_addr_q;
	logic [3:0] exec_bank_q;
	logic [15:0] refresh_mask_q;
	logic refresh_err_q;
	logic lat_start_q;
	logic row_start_q;
	logic [3:0] row_bank_q;
	logic rtt_on_q;
	logic [1:0] rtt_sel_q;

	// rebuild the full address from both captured parts
	function automatic logic [20:0] join_parts(input logic [20:0] ax,
		input logic [20:0] ay, input logic [1:0] bl);
		logic [20:0] r;
		r = ax & mad_pkg::MAD_AX_MASK; // [RULE8]
		for (int i = 0; i < mad_pkg::MAD_AY_N; i++) begin
			r[mad_pkg::MAD_AY_BIT[i]] = ay[mad_pkg::MAD_AY_BALL[i]]; // [RULE8]
		end
		if (bl == mad_pkg::MAD_BL_TWO
			|| (!IS_X36 && bl == mad_pkg::MAD_BL_FOUR)) begin
			r[19] = ay[mad_pkg::MAD_AY_BALL_A19]; // [RULE8] [RULE9]
		end
		if (!IS_X36 && bl == mad_pkg::MAD_BL_TWO) begin
			r[20] = ay[mad_pkg::MAD_AY_BALL_A20]; // [RULE9]
		end
		return r;
	endfunction : join_parts

	// two-flop capture of the mirror strap, a board level
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			strap_meta_q <= 1'b0;
			strap_q <= 1'b0;
		end else begin
			strap_meta_q <= ball_mirror_strap;
			strap_q <= strap_meta_q;
		end
	end

	// undo the mirrored ball placement before decoding
	assign pins = mad_pkg::mad_mirror({link.chip_sel_n, link.write_en_n,
		link.refresh_n, link.bank_sel, link.addr_ball}, strap_q); // [RULE1]
	assign cmd = pins[27:25];
	assign ba = pins[24:21];
	assign ab = pins[20:0];

	// command decode; second-part cycles carry no command
	assign issue = (phase_q == MAD_PH_CMD) && !cmd[2];
	assign multibank = mr1_q[mad_pkg::MAD_MR1_MB_BIT];
	assign bank_ref = (cmd == mad_pkg::MAD_CMD_AUTO_REFRESH_CMD) && !multibank;
	assign burst = mr1_q[mad_pkg::MAD_MR1_BL_LSB +: 2];

	// bank refresh needs no second part, so a new command may follow
	always_comb begin
		phase_d = MAD_PH_CMD;
		if (issue && muxed_q && !bank_ref) begin
			phase_d = MAD_PH_SECOND; // [RULE5] [RULE13] [RULE14]
		end
	end

	// phase and captured first part
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			phase_q <= MAD_PH_CMD;
			pend_bref_q <= 1'b0;
			held_cmd_q <= mad_pkg::MAD_CMD_NOP;
			held_ax_q <= 21'h000000;
			held_ba_q <= 4'h0;
		end else begin
			phase_q <= phase_d;
			pend_bref_q <= issue && muxed_q && bank_ref; // [RULE12]
			if (issue && muxed_q) begin
				held_cmd_q <= cmd; // [RULE20]
				held_ax_q <= ab; // [RULE20]
				held_ba_q <= ba;
			end
		end
	end

	// pick what executes on this edge
	always_comb begin
		go = 1'b0;
		ecmd = cmd;
		eaddr = ab;
		eba = ba;
		if (phase_q == MAD_PH_SECOND) begin
			go = 1'b1; // [RULE20] [RULE12]
			ecmd = held_cmd_q;
			eaddr = join_parts(held_ax_q, ab, burst); // [RULE5]
			eba = held_ba_q;
		end else if (pend_bref_q) begin
			go = 1'b1; // [RULE12]
			ecmd = mad_pkg::MAD_CMD_AUTO_REFRESH_CMD;
			eaddr = 21'h000000;
			eba = held_ba_q;
		end else if (issue && !muxed_q) begin
			go = 1'b1;
		end
	end

	// banks chosen by a refresh
	always_comb begin
		mask = 16'h0000;
		if (multibank) begin
			mask = eaddr[15:0]; // [RULE16] [RULE19]
		end else begin
			mask[eba] = 1'b1; // [RULE17]
		end
	end

	// mode registers and address mode
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mr0_q <= mad_pkg::MAD_MR_RESET;
			mr1_q <= mad_pkg::MAD_MR_RESET;
			mr2_q <= mad_pkg::MAD_MR_RESET;
			muxed_q <= 1'b0;
			mr2_done_q <= 1'b0;
		end else if (go && ecmd == mad_pkg::MAD_CMD_MRS) begin
			unique case (eba[1:0])
				mad_pkg::MAD_MR_SEL_ZERO: begin
					mr0_q <= eaddr;
					muxed_q <= eaddr[mad_pkg::MAD_MR0_MUX_BIT]; // [RULE2]
				end
				mad_pkg::MAD_MR_SEL_ONE: begin
					mr1_q <= eaddr;
				end
				mad_pkg::MAD_MR_SEL_TWO: begin
					mr2_q <= eaddr;
					mr2_done_q <= 1'b1; // [RULE18]
				end
				default: begin
					mr2_done_q <= mr2_done_q;
				end
			endcase
		end
	end

	// executed command, latency and refresh reporting
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			exec_valid_q <= 1'b0;
			exec_cmd_q <= mad_pkg::MAD_CMD_NOP;
			exec_addr_q <= 21'h000000;
			exec_bank_q <= 4'h0;
			refresh_mask_q <= 16'h0000;
			refresh_err_q <= 1'b0;
			lat_start_q <= 1'b0;
		end else begin
			exec_valid_q <= go;
			exec_cmd_q <= go ? ecmd : mad_pkg::MAD_CMD_NOP;
			exec_addr_q <= eaddr;
			exec_bank_q <= eba;
			refresh_mask_q <= (go && ecmd == mad_pkg::MAD_CMD_AUTO_REFRESH_CMD)
				? mask : 16'h0000; // [RULE12]
			refresh_err_q <= go && ecmd == mad_pkg::MAD_CMD_AUTO_REFRESH_CMD && multibank
				&& (5'($countones(mask)) > mad_pkg::MAD_MAX_REFRESH_BANKS); // [RULE19]
			lat_start_q <= go && (ecmd == mad_pkg::MAD_CMD_READ
				|| ecmd == mad_pkg::MAD_CMD_WRITE); // [RULE10]
		end
	end

	// row cycle reference is the command edge in both modes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			row_start_q <= 1'b0;
			row_bank_q <= 4'h0;
		end else begin
			row_start_q <= issue && cmd != mad_pkg::MAD_CMD_MRS; // [RULE11]
			row_bank_q <= ba;
		end
	end

	// termination stays off until register two has been written
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rtt_on_q <= 1'b0;
			rtt_sel_q <= mad_pkg::MAD_RTT_OFF;
		end else begin
			rtt_on_q <= mr2_done_q && (mr1_q[mad_pkg::MAD_MR1_RTT_LSB +: 2]
				!= mad_pkg::MAD_RTT_OFF); // [RULE18]
			rtt_sel_q <= mr1_q[mad_pkg::MAD_MR1_RTT_LSB +: 2];
		end
	end

	assign exec_valid = exec_valid_q;
	assign exec_cmd = exec_cmd_q;
	assign exec_addr = exec_addr_q;
	assign exec_bank = exec_bank_q;
	assign refresh_mask = refresh_mask_q;
	assign refresh_err = refresh_err_q;
	assign lat_start = lat_start_q;
	assign row_start = row_start_q;
	assign row_bank = row_bank_q;
	assign muxed_mode = muxed_q;
	assign burst_len = burst;
	assign rtt_on = rtt_on_q;
	assign rtt_sel = rtt_sel_q;
endmodule : mad_dram_end

`default_nettype wire

// File: hw/mad_ctrl_end.sv
// controller end: splits requests into one or two ball cycles
`timescale 1ns/1ns
`default_nettype none

module mad_ctrl_end #(
	parameter bit IS_X36 = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	mad_link_if.ctrl link,
	input wire logic ball_mirror_strap,
	input wire logic req_valid,
	input wire logic [2:0] req_cmd,
	input wire logic [20:0] req_addr,
	input wire logic [3:0] req_bank,
	output logic req_ready,
	output logic req_refused,
	output logic muxed_mode
);
	typedef enum logic [2:0] {
		MAD_CS_IDLE = 3'b001,
		MAD_CS_SECOND = 3'b010,
		MAD_CS_WAIT = 3'b100
	} mad_cstate_t;

	mad_cstate_t state_q;
	logic strap_meta_q;
	logic strap_q;
	logic [27:0] pins_q;
	logic [20:0] ay_q;
	logic muxed_q;
	logic multibank_q;
	logic [1:0] bl_q;
	logic [7:0] gap_q;
	logic [1:0] age_q;
	logic [7:0] saw_q;
	logic [4:0] saw_used_q;
	logic refused_q;
	logic is_mrs;
	logic is_auto_refresh_cmd;
	logic mb_ref;
	logic [20:0] addr;
	logic [3:0] bank;
	logic [20:0] ay_balls;
	logic [4:0] nbanks;
	logic bad_bl8;
	logic mmd_ok;
	logic saw_ok;
	logic take;
	logic fire;
	logic switching;

	// two-flop capture of the mirror strap
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			strap_meta_q <= 1'b0;
			strap_q <= 1'b0;
		end else begin
			strap_meta_q <= ball_mirror_strap;
			strap_q <= strap_meta_q;
		end
	end

	// request cleanup for mode sets
	assign is_mrs = req_cmd == mad_pkg::MAD_CMD_MRS;
	assign is_auto_refresh_cmd = req_cmd == mad_pkg::MAD_CMD_AUTO_REFRESH_CMD;
	always_comb begin
		addr = req_addr;
		bank = req_bank;
		if (is_mrs) begin
			addr = req_addr & ~mad_pkg::MAD_MR_RSVD_MASK; // [RULE6]
			bank = {2'h0, req_bank[1:0]}; // [RULE6]
			if (muxed_q && req_bank[1:0] == mad_pkg::MAD_MR_SEL_ZERO) begin
				addr[mad_pkg::MAD_MR0_MUX_BIT] = 1'b1; // [RULE4]
			end
		end
	end

	// second-part balls for the current burst length
	always_comb begin
		ay_balls = 21'h000000;
		for (int i = 0; i < mad_pkg::MAD_AY_N; i++) begin
			ay_balls[mad_pkg::MAD_AY_BALL[i]] = addr[mad_pkg::MAD_AY_BIT[i]]; // [RULE8]
		end
		if (bl_q == mad_pkg::MAD_BL_TWO
			|| (!IS_X36 && bl_q == mad_pkg::MAD_BL_FOUR)) begin
			ay_balls[mad_pkg::MAD_AY_BALL_A19] = addr[19]; // [RULE8] [RULE9]
		end
		if (!IS_X36 && bl_q == mad_pkg::MAD_BL_TWO) begin
			ay_balls[mad_pkg::MAD_AY_BALL_A20] = addr[20]; // [RULE9]
		end
	end

	// legality and spacing checks
	assign mb_ref = is_auto_refresh_cmd && multibank_q;
	assign nbanks = 5'($countones(req_addr[15:0]));
	assign bad_bl8 = IS_X36 && is_mrs
		&& req_bank[1:0] == mad_pkg::MAD_MR_SEL_ONE
		&& addr[mad_pkg::MAD_MR1_BL_LSB +: 2] == mad_pkg::MAD_BL_EIGHT; // [RULE7]
	assign mmd_ok = !mb_ref || nbanks <= mad_pkg::MAD_MMD_FREE_BANKS
		|| age_q >= mad_pkg::MAD_MULTIBANK_SPACING_CYC; // [RULE15]
	assign saw_ok = !mb_ref || saw_q == 8'h00
		|| (saw_used_q + nbanks) <= mad_pkg::MAD_MAX_REFRESH_BANKS; // [RULE15]
	assign req_ready = (state_q == MAD_CS_IDLE) && mmd_ok && saw_ok;
	assign take = req_valid && req_ready;
	assign fire = take && !bad_bl8 && !req_cmd[2];
	assign switching = fire && is_mrs && !muxed_q
		&& req_bank[1:0] == mad_pkg::MAD_MR_SEL_ZERO
		&& addr[mad_pkg::MAD_MR0_MUX_BIT];

	// ball sequencing
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_q <= MAD_CS_IDLE;
			pins_q <= {mad_pkg::MAD_CMD_NOP, 25'h0000000};
			ay_q <= 21'h000000;
			gap_q <= 8'h00;
		end else begin
			unique case (state_q)
				MAD_CS_IDLE: begin
					if (fire) begin
						pins_q <= {req_cmd, bank, muxed_q
							? (addr & mad_pkg::MAD_AX_MASK) : addr}; // [RULE5]
						ay_q <= ay_balls;
						if (switching) begin
							state_q <= MAD_CS_WAIT; // [RULE3]
							gap_q <= mad_pkg::MAD_MODE_SET_DELAY_CYC - 8'h01;
						end else if (muxed_q && !(is_auto_refresh_cmd && !multibank_q)) begin
							state_q <= MAD_CS_SECOND; // [RULE14] [RULE13]
						end
					end else begin
						pins_q <= {mad_pkg::MAD_CMD_NOP, 25'h0000000};
					end
				end
				MAD_CS_SECOND: begin
					pins_q <= {mad_pkg::MAD_CMD_NOP, 4'h0, ay_q}; // [RULE5]
					state_q <= MAD_CS_IDLE;
				end
				MAD_CS_WAIT: begin
					pins_q <= {mad_pkg::MAD_CMD_NOP, 25'h0000000};
					gap_q <= gap_q - 8'h01;
					if (gap_q <= 8'h01) begin
						state_q <= MAD_CS_IDLE; // [RULE3]
					end
				end
				default: begin
					state_q <= MAD_CS_IDLE;
				end
			endcase
		end
	end

	// controller copy of the device mode
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			muxed_q <= 1'b0;
			multibank_q <= 1'b0;
			bl_q <= mad_pkg::MAD_BL_TWO;
		end else if (fire && is_mrs) begin
			if (req_bank[1:0] == mad_pkg::MAD_MR_SEL_ZERO) begin
				muxed_q <= addr[mad_pkg::MAD_MR0_MUX_BIT]; // [RULE2]
			end
			if (req_bank[1:0] == mad_pkg::MAD_MR_SEL_ONE) begin
				multibank_q <= addr[mad_pkg::MAD_MR1_MB_BIT];
				bl_q <= addr[mad_pkg::MAD_MR1_BL_LSB +: 2];
			end
		end
	end

	// spacing trackers for multibank refresh
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			age_q <= 2'h3;
			saw_q <= 8'h00;
			saw_used_q <= 5'h00;
			refused_q <= 1'b0;
		end else begin
			refused_q <= take && bad_bl8; // [RULE7]
			if (fire) begin
				age_q <= 2'h0;
			end else if (age_q != 2'h3) begin
				age_q <= age_q + 2'h1;
			end
			if (fire && mb_ref && saw_q == 8'h00) begin
				saw_q <= mad_pkg::MAD_FOUR_ACT_WINDOW_CYC; // [RULE15]
				saw_used_q <= nbanks;
			end else begin
				if (saw_q != 8'h00) begin
					saw_q <= saw_q - 8'h01;
				end
				if (fire && mb_ref) begin
					saw_used_q <= saw_used_q + nbanks;
				end
			end
		end
	end

	// drive balls in the board's placement
	assign {link.chip_sel_n, link.write_en_n, link.refresh_n, link.bank_sel,
		link.addr_ball} = mad_pkg::mad_mirror(pins_q, strap_q); // [RULE1]
	assign req_refused = refused_q;
	assign muxed_mode = muxed_q;
endmodule : mad_ctrl_end

`default_nettype wire

// File: sim/mad_link_chk.sv
// concurrent checks on the command and address balls of the link
`timescale 1ns/1ns
`default_nettype none

module mad_link_chk #(
	parameter bit IS_X36 = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic chip_sel_n,
	input wire logic write_en_n,
	input wire logic refresh_n,
	input wire logic [3:0] bank_sel,
	input wire logic [20:0] addr_ball
);
	logic [2:0] cmd;
	logic mode_register_set_cmd, auto_refresh_cmd, sel_zero, sel_one;
	logic mux_q, mb_q;
	logic [7:0] wait_q;

	// decode of the command balls
	assign cmd = {chip_sel_n, write_en_n, refresh_n};
	assign mode_register_set_cmd = (cmd == mad_pkg::MAD_CMD_MRS);
	assign auto_refresh_cmd = (cmd == mad_pkg::MAD_CMD_AUTO_REFRESH_CMD);
	assign sel_zero = (bank_sel[1:0] == mad_pkg::MAD_MR_SEL_ZERO);
	assign sel_one = (bank_sel[1:0] == mad_pkg::MAD_MR_SEL_ONE);

	// shadow of the address mode as seen on the wire
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mux_q <= 1'b0;
		end else if (mode_register_set_cmd && sel_zero) begin
			mux_q <= addr_ball[mad_pkg::MAD_MR0_MUX_BIT];
		end
	end

	// shadow of the multibank refresh enable
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mb_q <= 1'b0;
		end else if (mode_register_set_cmd && sel_one) begin
			mb_q <= addr_ball[mad_pkg::MAD_MR1_MB_BIT];
		end
	end

	// quiet period after the switching mode set, full mode-set delay
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wait_q <= 8'h00;
		end else if (mode_register_set_cmd && sel_zero && addr_ball[9] && !mux_q) begin
			wait_q <= mad_pkg::MAD_MODE_SET_DELAY_CYC - 8'h01;
		end else if (wait_q != 8'h00) begin
			wait_q <= wait_q - 8'h01;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// a two-part command leaves the next cycle free of commands
	sequence s_part_two;
		##1 chip_sel_n;
	endsequence

	property p_two_part;
		(mux_q && !chip_sel_n && !(auto_refresh_cmd && !mb_q)) |-> s_part_two;
	endproperty
	a_two_part: assert property (p_two_part)
		else $error("command placed on a second address part cycle");

	property p_mb_gap;
		(mux_q && auto_refresh_cmd && mb_q) |-> s_part_two ##1 $past(chip_sel_n);
	endproperty
	a_mb_gap: assert property (p_mb_gap)
		else $error("command too soon after multibank refresh");

	property p_mrs_wait;
		!chip_sel_n |-> (wait_q == 8'h00);
	endproperty
	a_mrs_wait: assert property (p_mrs_wait)
		else $error("command inside the mode set delay");

	property p_mrs_bank;
		mode_register_set_cmd |-> (bank_sel[3:2] == 2'h0);
	endproperty
	a_mrs_bank: assert property (p_mrs_bank)
		else $error("bank bits two and three high during mode set");

	property p_mrs_rsvd;
		mode_register_set_cmd |-> ((addr_ball & mad_pkg::MAD_MR_RSVD_MASK & (mux_q ?
			mad_pkg::MAD_AX_MASK : 21'h1fffff)) == 21'h000000);
	endproperty
	a_mrs_rsvd: assert property (p_mrs_rsvd)
		else $error("reserved ball high during mode set");

	property p_mr0_keep;
		(mux_q && mode_register_set_cmd && sel_zero) |-> addr_ball[9];
	endproperty
	a_mr0_keep: assert property (p_mr0_keep)
		else $error("zero register rewritten without the mux bit");

	property p_no_bl8;
		(IS_X36 && mode_register_set_cmd && sel_one) |->
			(addr_ball[4:3] != mad_pkg::MAD_BL_EIGHT);
	endproperty
	a_no_bl8: assert property (p_no_bl8)
		else $error("burst of eight set on wide part");

	property p_mb_max4;
		(!mux_q && auto_refresh_cmd && mb_q) |-> ($countones(addr_ball[15:0]) <= 4);
	endproperty
	a_mb_max4: assert property (p_mb_max4)
		else $error("more than four banks in one refresh");
endmodule : mad_link_chk

`default_nettype wire

// File: sim/mad_link_tb.sv
// self-checking bench: controller end and memory end joined by the link
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	error_cnt++; $display("wrong value %s exp %h got %h", nm, ex, got); end end

module mad_link_tb;
	localparam logic [2:0] c_rd = mad_pkg::MAD_CMD_READ;
	localparam logic [2:0] c_wr = mad_pkg::MAD_CMD_WRITE;
	localparam logic [2:0] c_ref = mad_pkg::MAD_CMD_AUTO_REFRESH_CMD;
	localparam logic [2:0] c_mrs = mad_pkg::MAD_CMD_MRS;
	localparam logic [20:0] exp_a [0:2] = '{21'h1abcde, 21'h0abcde, 21'h02bcde};
	logic core_clk, rst_b, req_valid, req_ready, req_refused, ctrl_mux;
	logic [2:0] req_cmd, exec_cmd, e_cmd;
	logic [20:0] req_addr, exec_addr, e_addr;
	logic [3:0] req_bank, exec_bank, e_bank, row_bank;
	logic [15:0] refresh_mask, e_mask;
	logic exec_valid, refresh_err, lat_start, row_start, dram_mux, rtt_on;
	logic [1:0] burst_len, rtt_sel;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int t_req, t_prev, t_exec, t_lat, t_row, t_ref, d_exec, d_lat, d_row, d_ref;

	mad_link_if link();

	mad_ctrl_end #(.IS_X36(1'b0)) i_mad_ctrl_end (.core_clk(core_clk),
		.rst_b(rst_b), .link(link.ctrl), .ball_mirror_strap(1'b0),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_bank(req_bank), .req_ready(req_ready),
		.req_refused(req_refused), .muxed_mode(ctrl_mux));

	mad_dram_end #(.IS_X36(1'b0)) i_mad_dram_end (.core_clk(core_clk),
		.rst_b(rst_b), .link(link.dram), .ball_mirror_strap(1'b0),
		.exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_addr(exec_addr),
		.exec_bank(exec_bank), .refresh_mask(refresh_mask),
		.refresh_err(refresh_err), .lat_start(lat_start),
		.row_start(row_start), .row_bank(row_bank), .muxed_mode(dram_mux),
		.burst_len(burst_len), .rtt_on(rtt_on), .rtt_sel(rtt_sel));

	mad_link_chk #(.IS_X36(1'b0)) i_mad_link_chk (.core_clk(core_clk),
		.rst_b(rst_b), .chip_sel_n(link.chip_sel_n),
		.write_en_n(link.write_en_n), .refresh_n(link.refresh_n),
		.bank_sel(link.bank_sel), .addr_ball(link.addr_ball));

	// free-running command clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// record the cycle and contents of every pulse from the memory end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (exec_valid === 1'b1) begin
			e_cmd <= exec_cmd;
			e_addr <= exec_addr;
			e_bank <= exec_bank;
			t_exec <= cyc;
		end
		if (exec_valid === 1'b1 && exec_cmd === c_ref) begin
			e_mask <= refresh_mask;
			t_ref <= cyc;
		end
		if (lat_start === 1'b1) t_lat <= cyc;
		if (row_start === 1'b1) t_row <= cyc;
	end

	// hold a request until the controller takes it
	task automatic req(input logic [2:0] c, input logic [20:0] a,
		input logic [3:0] b);
		int n;
		n = 0;
		t_prev = t_req;
		req_valid <= 1'b1;
		req_cmd <= c;
		req_addr <= a;
		req_bank <= b;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		t_req = cyc;
	endtask : req

	// drop the request and let cycles pass
	task automatic idle(input int k);
		req_valid <= 1'b0;
		repeat (k) @(posedge core_clk);
	endtask : idle

	// verdict and end of run
	task automatic wrap_up();
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// cut a hang short
	initial begin
		repeat (4000) @(posedge core_clk);
		error_cnt++;
		wrap_up();
	end

	// main sequence
	initial begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_cmd = 3'h7;
		req_addr = 21'h000000;
		req_bank = 4'h0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		`CHK("exec_cmd", mad_pkg::MAD_CMD_NOP, exec_cmd)
		`CHK("muxed", 1'b0, dram_mux)
		// plain addressing gives the reference timing
		req(c_rd, 21'h1abcde, 4'h5);
		idle(8);
		`CHK("addr", 21'h1abcde, e_addr)
		d_exec = t_exec - t_req;
		d_lat = t_lat - t_req;
		d_row = t_row - t_req;
		req(c_ref, 21'h00ffff, 4'h3);
		idle(8);
		d_ref = t_ref - t_req;
		`CHK("bank mask", 16'h0008, e_mask)
		// switch to muxed addressing, controller must hold off
		req(c_mrs, 21'h000200, 4'h0);
		idle(3);
		`CHK("ready in wait", 1'b0, req_ready)
		idle(12);
		`CHK("dram muxed", 1'b1, dram_mux)
		`CHK("ctrl muxed", 1'b1, ctrl_mux)
		req(c_mrs, 21'h000200, 4'h0);
		req(c_mrs, 21'h000020, 4'h1);
		idle(6);
		`CHK("burst", mad_pkg::MAD_BL_TWO, burst_len)
		`CHK("rtt sel", 2'h1, rtt_sel)
		`CHK("rtt before two", 1'b0, rtt_on)
		req(c_mrs, 21'h000000, 4'h2);
		idle(6);
		`CHK("rtt after two", 1'b1, rtt_on)
		`CHK("still muxed", 1'b1, dram_mux)
		// two-part read: timing references
		req(c_rd, 21'h1abcde, 4'h5);
		idle(8);
		`CHK("mux addr", 21'h1abcde, e_addr)
		`CHK("mux bank", 4'h5, e_bank)
		`CHK("exec delay", d_exec + 1, t_exec - t_req)
		`CHK("latency ref", d_lat + 1, t_lat - t_req)
		`CHK("row ref", d_row, t_row - t_req)
		// address split for every burst length
		for (int i = 0; i < 3; i++) begin
			req(c_mrs, 21'h000020 | (21'(i) << 3), 4'h1);
			req(c_wr, 21'h1abcde, 4'h2);
			idle(8);
			`CHK("burst", 2'(i), burst_len)
			`CHK("cmd", c_wr, e_cmd)
			`CHK("split addr", exp_a[i], e_addr)
		end
		// bank refresh lets the next command follow at once
		req(c_ref, 21'h00ffff, 4'h9);
		req(c_rd, 21'h000004, 4'h1);
		`CHK("bank auto_refresh_cmd gap", 1, t_req - t_prev)
		idle(8);
		`CHK("bank auto_refresh_cmd exec", d_ref + 1, t_ref - t_prev)
		`CHK("bank mask", 16'h0200, e_mask)
		// multibank refresh with its bank bits carried on first-part balls only
		req(c_mrs, 21'h000128, 4'h1);
		idle(4);
		req(c_ref, 21'h000411, 4'hf);
		req(c_rd, 21'h000004, 4'h1);
		`CHK("mb gap", 2, t_req - t_prev)
		idle(8);
		`CHK("mb exec", d_ref + 1, t_ref - t_prev)
		`CHK("mb mask", 16'h0411, e_mask)
		wrap_up();
	end
endmodule : mad_link_tb

`default_nettype wire
